// ==== verilog/wdt_pkg.sv ====
package wdt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_MHZ = 250;
  localparam int HOLD_MS = 18;
  localparam int HOLD_CYCLES = HOLD_MS * CLK_MHZ * 1000;
  localparam int WDT_BASE_MS = 18;
  // nominal period of the watchdog rc oscillator, plain default
  localparam int WDT_OSC_NS = 1000;
  localparam int WDT_BASE_TICKS = WDT_BASE_MS * 1000000 / WDT_OSC_NS;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int ADDR_W = 5;
  localparam int HOLD_W = 24;
  localparam int WDT_W = 16;
  localparam int SCALE_W = 8;
  localparam int FUSE_W = 12;
  localparam int OPT_W = 6;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets, byte addresses
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_OPTION = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_CMD = 5'h0C;
  localparam logic [ADDR_W-1:0] OFF_WDT = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int FUSE_OSC_LO = 0;
  localparam int FUSE_WATCHDOG_ENABLE_FUSE = 2;
  localparam int FUSE_CP = 3;
  localparam int OPT_RATIO_LO = 0;
  localparam int OPT_ASSIGN = 3;
  localparam int STAT_SLEEP = 0;
  localparam int STAT_RST = 1;
  localparam int STAT_OSC_OFF = 2;
  localparam int STAT_PD = 3;
  localparam int STAT_TO = 4;
  localparam int CMD_CLR = 0;
  localparam int CMD_SLEEP = 1;
  localparam int CMD_TMR = 2;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [FUSE_W-1:0] FUSE_RESET = 12'hFFF;
  localparam logic [OPT_W-1:0] OPTION_RESET = 6'h3F;

  typedef enum logic [1:0] {
    low_power_crystal_mode,
    standard_crystal_mode,
    high_speed_crystal_mode,
    rc_osc_mode
  } osc_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } av_req_t;

  typedef struct packed {
    logic [FUSE_W-1:0] fuse;
    logic fuse_ok;
    logic [OPT_W-1:0] option;
    logic to_n;
    logic pd_n;
    logic sleeping;
    logic osc_off;
    logic cpu_rst;
    logic [HOLD_W-1:0] hold;
    logic [WDT_W-1:0] wdt;
    logic [SCALE_W-1:0] scale;
    logic t0_out;
    logic [1:0] tick_s;
    logic tick_prev;
    logic [1:0] mclr_s;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  localparam state_t STATE_RESET = '{
    fuse: FUSE_RESET,
    option: OPTION_RESET,
    to_n: 1'h1,
    pd_n: 1'h1,
    cpu_rst: 1'h1,
    hold: HOLD_W'(HOLD_CYCLES),
    mclr_s: 2'h3,
    default: '0
  };

endpackage

// ==== verilog/wdt_fuse_ctrl.sv ====
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps

// Function
// - only the fuse can stop the watchdog; it also sits at zero through the reset hold
// - watchdog runs on own rc oscillator
// - counts on while main oscillator stops
// - hold timer keeps reset 18 ms
// - sleep left only by reset/time-out
// - time-out causes full device reset
// - time-out clears time-out flag
// - enable fuse bit 2 gates watchdog
// - fuse bit 3 low protects code
// - fuse bits 1:0 pick oscillator
// - one 8-bit shared scaler
// - scaler owner is exclusive
// - option bits 3:0 pick owner, ratio
// - bare watchdog times out 18 ms
// - postscaler reaches 1:128
// - clear instruction restarts watchdog
// - sleep instruction restarts watchdog
// - sleep sets time-out flag, clears power-down flag, stops oscillator
// - wake-up always clears watchdog
// - timer write clears scaler unless watchdog owns it
module wdt_fuse_ctrl
  import wdt_pkg::*;
#(
  parameter int HOLD_COUNT = HOLD_CYCLES,
  parameter int BASE_TICKS = WDT_BASE_TICKS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [FUSE_W-1:0] config_fuses,
  input wire logic wdt_osc_clk,
  input wire logic ext_reset_n,
  input wire logic t0_tick,
  input wire av_req_t bus_req,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic t0_scaled,
  output logic cpu_reset,
  output logic osc_driver_off,
  output logic sleeping,
  output logic timeout_flag_n,
  output logic powerdown_flag_n,
  output logic watchdog_on,
  output logic code_protect_on,
  output osc_mode_t osc_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic [SCALE_W-1:0] ratio_mask(input logic [3:0] n);
    ratio_mask = SCALE_W'((9'h001 << n) - 9'h001);
  endfunction

  state_t q;
  state_t d;
  logic wr_ok;
  logic rd_go;
  logic cpu_run;
  logic tick_edge;
  logic en;
  logic run;
  logic assign_wdt;
  logic [2:0] ratio;
  logic [SCALE_W-1:0] wmask;
  logic [SCALE_W-1:0] tmask;
  logic base_wrap;
  logic to_ev;
  logic ext_rst;
  logic cmd_hit;
  logic clr_cmd;
  logic slp_cmd;
  logic tmr_cmd;
  logic opt_wr;
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // bus side: one wait state, answer on the second edge

  assign waitrequest = (bus_req.read | bus_req.write) & ~q.ack;
  assign wr_ok = bus_req.write & q.ack;
  assign rd_go = bus_req.read & ~q.ack;
  // a halted or sleeping core issues no instructions
  assign cpu_run = ~q.cpu_rst & ~q.sleeping;
  assign cmd_hit = wr_ok & (bus_req.address == OFF_CMD) & cpu_run;
  assign clr_cmd = cmd_hit & bus_req.writedata[CMD_CLR];
  assign slp_cmd = cmd_hit & bus_req.writedata[CMD_SLEEP];
  assign tmr_cmd = cmd_hit & bus_req.writedata[CMD_TMR];
  assign opt_wr = wr_ok & (bus_req.address == OFF_OPTION) & cpu_run;

  always_comb begin
    status_word = '0;
    status_word[STAT_SLEEP] = q.sleeping;
    status_word[STAT_RST] = q.cpu_rst;
    status_word[STAT_OSC_OFF] = q.osc_off;
    status_word[STAT_PD] = q.pd_n;
    status_word[STAT_TO] = q.to_n;
  end

  always_comb begin
    case (bus_req.address)
      OFF_CONFIG: rd_mux = {20'h00000, q.fuse};
      OFF_OPTION: rd_mux = {26'h0000000, q.option};
      OFF_STATUS: rd_mux = status_word;
      OFF_WDT: rd_mux = {16'h0000, q.wdt};
      default: rd_mux = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog and shared scaler decode

  assign en = q.fuse_ok & q.fuse[FUSE_WATCHDOG_ENABLE_FUSE];
  assign run = en & ~q.cpu_rst;
  assign assign_wdt = q.option[OPT_ASSIGN];
  assign ratio = q.option[OPT_RATIO_LO +: 3];
  assign wmask = ratio_mask({1'b0, ratio});
  assign tmask = ratio_mask({1'b0, ratio} + 4'h1);
  // second flop only; first sync stage feeds nothing else
  assign tick_edge = q.tick_s[1] & ~q.tick_prev;
  assign base_wrap = run & tick_edge & (q.wdt == WDT_W'(BASE_TICKS - 1));
  // without the scaler every base period ends in a time-out
  assign to_ev = base_wrap & (~assign_wdt | ((q.scale & wmask) == wmask));
  assign ext_rst = ~q.mclr_s[1];

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    d.tick_s = {q.tick_s[0], wdt_osc_clk};
    d.tick_prev = q.tick_s[1];
    d.mclr_s = {q.mclr_s[0], ext_reset_n};
    d.t0_out = 1'b0;
    d.ack = (bus_req.read | bus_req.write) & ~q.ack;
    if (rd_go) begin
      d.rdata = rd_mux;
    end
    // fuses are static; catch them once after release
    if (!q.fuse_ok) begin
      d.fuse = config_fuses;
      d.fuse_ok = 1'b1;
    end
    if (opt_wr) begin
      d.option = bus_req.writedata[OPT_W-1:0];
    end
    if (q.hold != '0) begin
      d.hold = q.hold - HOLD_W'(1);
    end
    // keeps counting in sleep: fed by its own oscillator
    if (run && tick_edge) begin
      if (base_wrap) begin
        d.wdt = '0;
        if (assign_wdt) begin
          d.scale = q.scale + SCALE_W'(1);
        end
      end else begin
        d.wdt = q.wdt + WDT_W'(1);
      end
    end
    if (!run) begin
      d.wdt = '0;
    end
    if (!assign_wdt && t0_tick && !q.cpu_rst) begin
      d.scale = q.scale + SCALE_W'(1);
      d.t0_out = (q.scale & tmask) == tmask;
    end
    if (clr_cmd) begin
      d.wdt = '0;
      if (assign_wdt) begin
        d.scale = '0;
      end
      d.to_n = 1'b1;
      d.pd_n = 1'b1;
    end
    if (tmr_cmd && !assign_wdt) begin
      d.scale = '0;
    end
    if (slp_cmd) begin
      d.wdt = '0;
      if (assign_wdt) begin
        d.scale = '0;
      end
      d.to_n = 1'b1;
      d.pd_n = 1'b0;
      d.osc_off = 1'b1;
      d.sleeping = 1'b1;
    end
    // resets last: a time-out beats a flag set in the same cycle
    if (ext_rst || to_ev) begin
      d.wdt = '0;
      d.scale = '0;
      d.option = OPTION_RESET;
      d.sleeping = 1'b0;
      d.osc_off = 1'b0;
      d.hold = HOLD_W'(HOLD_COUNT);
      if (to_ev) begin
        d.to_n = 1'b0;
      end
    end
    d.cpu_rst = d.hold != '0;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= STATE_RESET;
      q.hold <= HOLD_W'(HOLD_COUNT);
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign readdata = q.rdata;
  assign t0_scaled = q.t0_out;
  assign cpu_reset = q.cpu_rst;
  assign osc_driver_off = q.osc_off;
  assign sleeping = q.sleeping;
  assign timeout_flag_n = q.to_n;
  assign powerdown_flag_n = q.pd_n;
  assign watchdog_on = en;
  assign code_protect_on = q.fuse_ok & ~q.fuse[FUSE_CP];
  assign osc_mode = osc_mode_t'(q.fuse[FUSE_OSC_LO +: 2]);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_sleep_go;
    slp_cmd && !to_ev && !ext_rst;
  endsequence

  sequence s_asleep;
    sleeping && osc_driver_off && !powerdown_flag_n && timeout_flag_n && q.wdt == '0;
  endsequence

  a_fuse_gates_wdt: assert property (
    !watchdog_on |-> q.wdt == '0 && !to_ev)
    else $error("watchdog moved while fuse off");

  a_fuse_enable: assert property (
    $rose(q.fuse_ok) |-> watchdog_on == $past(config_fuses[FUSE_WATCHDOG_ENABLE_FUSE]))
    else $error("enable fuse not honoured");

  a_tick_sync: assert property (
    tick_edge |-> $past(wdt_osc_clk, 2) && !$past(wdt_osc_clk, 3))
    else $error("tick not two flops behind pin");

  a_tick_count: assert property (
    run && tick_edge && !base_wrap && !clr_cmd && !slp_cmd && !ext_rst
    |=> q.wdt == $past(q.wdt) + 16'h0001)
    else $error("watchdog missed an oscillator tick");

  a_hold_release: assert property (
    $fell(cpu_reset) |-> $past(q.hold) == 24'h000001 && q.hold == '0)
    else $error("reset released before hold ran out");

  a_sleep_stays: assert property (
    sleeping && !ext_rst && !to_ev |=> sleeping)
    else $error("sleep left without reset");

  a_timeout_reset: assert property (
    to_ev |=> cpu_reset && !timeout_flag_n && !sleeping && q.wdt == '0)
    else $error("time-out did not reset device");

  a_timeout_flag: assert property (
    $fell(timeout_flag_n) |-> $past(to_ev))
    else $error("time-out flag cleared without time-out");

  a_cp_decode: assert property (
    $rose(q.fuse_ok) |-> code_protect_on == !$past(config_fuses[FUSE_CP]))
    else $error("code protect decode wrong");

  a_osc_decode: assert property (
    $rose(q.fuse_ok) |-> osc_mode == osc_mode_t'($past(config_fuses[1:0])))
    else $error("oscillator select decode wrong");

  a_scaler_excl: assert property (
    assign_wdt |=> !t0_scaled)
    else $error("timer pulse while scaler on watchdog");

  a_bare_timeout: assert property (
    !assign_wdt && base_wrap |=> cpu_reset && !timeout_flag_n)
    else $error("bare watchdog period not honoured");

  a_option_write: assert property (
    opt_wr && !ext_rst && !to_ev |=> q.option == $past(bus_req.writedata[OPT_W-1:0]))
    else $error("option write lost");

  a_ratio_hold: assert property (
    assign_wdt && base_wrap && q.scale == 8'h00 && ratio != 3'h0 |-> !to_ev)
    else $error("time-out before ratio elapsed");

  a_clear_instr: assert property (
    clr_cmd && !to_ev && !ext_rst
    |=> q.wdt == '0 && (!$past(assign_wdt) || q.scale == '0))
    else $error("clear instruction left count");

  a_sleep_entry: assert property (
    s_sleep_go |=> s_asleep)
    else $error("sleep entry state wrong");

  a_wake_clear: assert property (
    $fell(sleeping) |-> q.wdt == '0)
    else $error("watchdog not cleared on wake-up");

  a_timer_write: assert property (
    tmr_cmd && !assign_wdt |=> q.scale == '0)
    else $error("timer write kept scaler");

endmodule

// ==== tb/watchdog_and_config_fuses_tb.sv ====
`timescale 1ns/100ps
module watchdog_and_config_fuses_tb;
  import wdt_pkg::*;
  localparam int HC = 20;
  localparam int BT = 5;
  logic clock = 0;
  logic rst = 1;
  logic [FUSE_W-1:0] config_fuses = 12'hFFF;
  logic wdt_osc_clk = 0;
  logic ext_reset_n = 1;
  logic t0_tick = 0;
  av_req_t bus_req = '0;
  logic [31:0] readdata;
  logic waitrequest, t0_scaled, cpu_reset, osc_driver_off, sleeping;
  logic timeout_flag_n, powerdown_flag_n, watchdog_on, code_protect_on;
  osc_mode_t osc_mode;
  int failures = 0;
  int tests_run = 0;
  int pulses = 0;
  logic noise = 0;
  logic [31:0] rd;
  logic [5:0] o;

  wdt_fuse_ctrl #(.HOLD_COUNT(HC), .BASE_TICKS(BT)) dut_u (
    .clock(clock), .rst(rst), .config_fuses(config_fuses), .wdt_osc_clk(wdt_osc_clk),
    .ext_reset_n(ext_reset_n), .t0_tick(t0_tick), .bus_req(bus_req), .readdata(readdata),
    .waitrequest(waitrequest), .t0_scaled(t0_scaled), .cpu_reset(cpu_reset),
    .osc_driver_off(osc_driver_off), .sleeping(sleeping), .timeout_flag_n(timeout_flag_n),
    .powerdown_flag_n(powerdown_flag_n), .watchdog_on(watchdog_on),
    .code_protect_on(code_protect_on), .osc_mode(osc_mode));

  initial begin
    forever #2 clock = ~clock;
  end

  // random timer0 events must never disturb the watchdog postscaler
  always @(posedge clock) begin
    if (noise) t0_tick <= 1'($urandom_range(0, 1));
    if (t0_scaled) pulses <= pulses + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_req <= '{address: a, read: !w, write: w, writedata: d};
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    rd = readdata;
    bus_req <= '0;
  endtask

  task automatic run_wait(output int n);
    n = 0;
    while (cpu_reset !== 1'b0 && n < 200) begin
      @(negedge clock);
      n++;
    end
  endtask

  // slow osc, each level several clocks so the synchroniser sees it
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clock) wdt_osc_clk <= 1;
      repeat (4) @(posedge clock);
      wdt_osc_clk <= 0;
      repeat (4) @(posedge clock);
    end
  endtask

  task automatic tick0(input int n);
    repeat (n) begin
      @(posedge clock) t0_tick <= 1;
      @(posedge clock) t0_tick <= 0;
    end
    repeat (3) @(negedge clock);
  endtask

  task automatic boot(input logic [FUSE_W-1:0] f);
    int n;
    @(posedge clock);
    rst <= 1;
    config_fuses <= f;
    repeat (5) @(posedge clock);
    rst <= 0;
    run_wait(n);
    check("hold", 1, n >= HC && n <= HC + 2);
    check("osc", f[1:0], osc_mode);
    check("wdt_on", f[2], watchdog_on);
    check("cp_on", !f[3], code_protect_on);
    bus(0, OFF_CONFIG, 0);
    check("config", f, rd);
  endtask

  function automatic int exp_ticks(input logic [5:0] p);
    return p[3] ? BT << p[2:0] : BT;
  endfunction

  task automatic expire(input logic [5:0] p, input logic slp);
    int n;
    bus(1, OFF_OPTION, p);
    bus(1, OFF_CMD, slp ? 32'h2 : 32'h1);
    ticks(exp_ticks(p) - 1);
    check("early", 0, cpu_reset);
    ticks(1);
    check("reset", 1, cpu_reset);
    check("to_n", 0, timeout_flag_n);
    check("awake", 0, sleeping);
    run_wait(n);
    bus(0, OFF_OPTION, 0);
    check("opt", 32'h3F, rd);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    void'($urandom(32'h995d));
    for (int i = 0; i < 16; i++) boot({8'($urandom), 4'(i)});
    // watchdog stopped by its fuse alone
    boot({8'($urandom), 4'hB});
    bus(1, OFF_OPTION, 32'h0);
    bus(1, OFF_CMD, 32'h1);
    ticks(BT + 2);
    check("off", 0, cpu_reset);
    bus(0, OFF_WDT, 0);
    check("off_cnt", 0, rd);
    boot({8'($urandom), 4'hF});
    bus(0, 5'h1C, 0);
    check("unmapped", 0, rd);
    bus(1, OFF_CONFIG, 0);
    bus(0, OFF_CONFIG, 0);
    check("config_ro", config_fuses, rd);
    // timer0 scaler, 1:4
    bus(1, OFF_OPTION, 32'h1);
    bus(1, OFF_CMD, 32'h4);
    n = pulses;
    tick0(8);
    check("t0_div", 2, pulses - n);
    tick0(3);
    bus(1, OFF_CMD, 32'h4);
    n = pulses;
    tick0(3);
    check("t0_clr", 0, pulses - n);
    bus(1, OFF_OPTION, 32'h8);
    n = pulses;
    tick0(8);
    check("t0_none", 0, pulses - n);
    noise <= 1;
    for (int k = 0; k < 9; k++) begin
      o = k == 8 ? 6'h00 : 6'h08 | 6'(k);
      expire(o, 0);
    end
    expire(6'h00, 1);
    // sleep entry, wake by external reset
    bus(1, OFF_CMD, 32'h2);
    @(negedge clock);
    check("osc_off", 1, osc_driver_off);
    check("pd_n", 0, powerdown_flag_n);
    check("to_n_s", 1, timeout_flag_n);
    bus(0, OFF_STATUS, 0);
    check("status", 32'h15, rd);
    ticks(2);
    bus(0, OFF_WDT, 0);
    check("wdt_slp", 2, rd);
    @(posedge clock) ext_reset_n <= 0;
    repeat (5) @(negedge clock);
    check("ext_rst", 1, cpu_reset);
    check("ext_wake", 0, sleeping);
    @(posedge clock) ext_reset_n <= 1;
    run_wait(n);
    bus(0, OFF_WDT, 0);
    check("wdt_wake", 0, rd);
    conclude;
  end

  initial begin
    repeat (60000) @(posedge clock);
    failures++;
    conclude;
  end
endmodule
